// ==== core/dmaarb_latency.sv ====
/*
 * One channel's trigger slot: pending bit, response age and the
 * hold-off delay line.
 * Assumes a trigger and all controls on clk_sys, reset already synced.
 */
`timescale 1ns/1ps
`include "dmaarb_defs.svh"

module dmaarb_latency (
    input  wire logic clk_sys,
    input  wire logic rst_sync_n,
    input  wire logic trig,
    input  wire logic hold_off,
    input  wire logic ack,
    input  wire logic clear,
    output logic      pend,
    output logic      ready
);
    import dmaarb_pkg::*;

    logic                 pend_q;
    logic [`DA_AGE_W-1:0] age_q;
    logic [`DA_HOLD_DLY-1:0] hold_q;

    // Hold-off needs two clocks to take effect
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hold_q <= '0;
        end else begin
            hold_q <= {hold_q[`DA_HOLD_DLY-2:0], hold_off};
        end
    end

    // Only one trigger is kept; extra ones are dropped
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pend_q <= 1'b0;
        end else if (clear || ack) begin
            pend_q <= 1'b0;
        end else if (trig) begin
            pend_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            age_q <= '0;
        end else if (!pend_q || clear || ack) begin
            age_q <= '0;
        end else if (age_q != `DA_AGE_MAX) begin
            age_q <= age_q + 4'h1;
        end
    end

    assign pend  = pend_q;
    assign ready = pend_q && !hold_q[`DA_HOLD_DLY-1] &&
                   (age_q >= `DA_AGE_READY);

endmodule : dmaarb_latency

// ==== core/dmaarb_top.sv ====
/*
 * Four-channel DMA arbiter with APB registers, trigger latency,
 * CPU-instruction hold-offs, standby handling and done interrupts.
 * Assumes triggers and CPU status come from logic on clk_sys and that
 * the shared bus accepts one two-clock transfer at a time.
 */
`timescale 1ns/1ps
`include "dmaarb_defs.svh"

// Overview of operation
// - A request arriving during a transfer waits until that transfer ends.
// - Simultaneous requests are granted channel 0 first, channel 3 last.
// - A transfer coinciding with an interrupt goes first, then servicing.
// - A transfer starts 3 to 10 clocks after its trigger.
// - Each transfer holds the bus for two clocks.
// - A suppressing instruction in progress delays the start further.
// - Light sleep keeps transfers running; deep sleep stops them all.
// - New requests wait one cycle after listed suppressing instructions.
// - The RAM pointer increments after each transfer.
// - Pointer in register area or past RAM loses or corrupts data.
// - Flash access right after a transfer gets a three-clock wait.
// - Under hold-off one trigger is kept and served once released.
// - Count reaching zero clears active flag and raises done interrupt.
// - Software abort stops within two clocks, keeps values, no interrupt.
module dmaarb_top (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [`DA_PAW-1:0]    paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [`DA_NCH-1:0]    trig,
    input  wire dmaarb_pkg::dmaarb_cpu_t cpu,
    output dmaarb_pkg::dmaarb_bus_t    bus,
    output logic                       cpu_irq_allow,
    output logic                       cpu_wait,
    output logic                       irq
);
    import dmaarb_pkg::*;

    logic [1:0]                rst_q;
    logic                      rst_sync_n;
    logic [`DA_AW-1:0]         ptr_q   [`DA_NCH];
    logic [`DA_CW-1:0]         cnt_q   [`DA_NCH];
    logic [`DA_NCH-1:0]        en_q;
    logic [`DA_NCH-1:0]        act_q;
    logic [`DA_NCH-1:0]        hold_q;
    logic [`DA_NCH-1:0]        dir_q;
    logic [`DA_NCH-1:0]        istat_q;
    logic [`DA_NCH-1:0]        imask_q;
    logic [`DA_NCH-1:0]        swtrig_q;
    logic [`DA_NCH-1:0]        pend;
    logic [`DA_NCH-1:0]        ready;
    logic [`DA_NCH-1:0]        ack;
    logic [`DA_NCH-1:0]        cand;
    logic [`DA_NCH-1:0]        done;
    logic [`DA_NCH-1:0]        abort;
    dmaarb_state_t             state_q;
    logic [`DA_CHW-1:0]        cur_q;
    logic                      supp_q;
    logic                      after_xfer_q;
    logic [1:0]                wait_cnt_q;
    logic                      grant;
    logic                      apb_acc;
    logic                      apb_wr;
    logic                      apb_bad;
    logic [31:0]               rd_mux;
    logic                      fin;

    // Pointer falls in register area or outside RAM
    function automatic logic addr_bad(input logic [`DA_AW-1:0] a);
        addr_bad = (a >= `DA_GPR_LO && a <= `DA_GPR_HI) ||
                   (a < `DA_RAM_LO) || (a > `DA_RAM_HI);
    endfunction : addr_bad

    // Lowest set bit wins
    function automatic logic [`DA_NCH-1:0] pick_low(
        input logic [`DA_NCH-1:0] v
    );
        pick_low = v & (~v + 4'h1);
    endfunction : pick_low

    function automatic logic [`DA_CHW-1:0] enc(
        input logic [`DA_NCH-1:0] v
    );
        enc = '0;
        for (int i = `DA_NCH - 1; i >= 0; i--) begin
            if (v[i]) begin
                enc = i[`DA_CHW-1:0];
            end
        end
    endfunction : enc

    // Reset release through two flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_q <= 2'b00;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_q[1];

    // APB: one wait state, answer registered
    assign apb_acc = psel && penable && pready;
    assign apb_wr  = apb_acc && pwrite;
    assign apb_bad = !((paddr <= `DA_CNT_LAST) || (paddr == `DA_OFF_CTRL) ||
                       (paddr == `DA_OFF_ISTAT) || (paddr == `DA_OFF_IMASK) ||
                       (paddr == `DA_OFF_STATUS) || (paddr == `DA_OFF_TRIG))
                     || (paddr[1:0] != 2'b00);

    always_comb begin
        rd_mux = `DA_ZERO32;
        if (paddr <= `DA_PTR_LAST) begin
            rd_mux[`DA_AW-1:0] = ptr_q[paddr[3:2]];
        end else if (paddr <= `DA_CNT_LAST) begin
            rd_mux[`DA_CW-1:0] = cnt_q[paddr[3:2]];
        end else if (paddr == `DA_OFF_CTRL) begin
            rd_mux[`DA_F_EN+:`DA_NCH]   = en_q;
            rd_mux[`DA_F_ACT+:`DA_NCH]  = act_q;
            rd_mux[`DA_F_HOLD+:`DA_NCH] = hold_q;
            rd_mux[`DA_F_DIR+:`DA_NCH]  = dir_q;
        end else if (paddr == `DA_OFF_ISTAT) begin
            rd_mux[`DA_NCH-1:0] = istat_q;
        end else if (paddr == `DA_OFF_IMASK) begin
            rd_mux[`DA_NCH-1:0] = imask_q;
        end else if (paddr == `DA_OFF_STATUS) begin
            rd_mux[`DA_F_PEND+:`DA_NCH] = pend;
            rd_mux[`DA_F_BUSY]          = (state_q != DA_IDLE);
            rd_mux[`DA_F_CUR+:`DA_CHW]  = cur_q;
            rd_mux[`DA_F_BAD]           = addr_bad(ptr_q[cur_q]);
        end
        if (apb_bad) begin
            rd_mux = `DA_ZERO32;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `DA_ZERO32;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && apb_bad;
            if (psel && penable && !pready && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // Channel controls; hardware clears the active flag at completion
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            en_q   <= '0;
            act_q  <= '0;
            hold_q <= '0;
            dir_q  <= '0;
        end else begin
            if (apb_wr && paddr == `DA_OFF_CTRL) begin
                en_q   <= pwdata[`DA_F_EN+:`DA_NCH];
                act_q  <= pwdata[`DA_F_ACT+:`DA_NCH] &
                          pwdata[`DA_F_EN+:`DA_NCH];
                hold_q <= pwdata[`DA_F_HOLD+:`DA_NCH];
                dir_q  <= pwdata[`DA_F_DIR+:`DA_NCH];
            end else begin
                act_q  <= act_q & ~done;
            end
        end
    end

    // Software trigger is a one-cycle pulse
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            swtrig_q <= '0;
        end else if (apb_wr && paddr == `DA_OFF_TRIG) begin
            swtrig_q <= pwdata[`DA_NCH-1:0];
        end else begin
            swtrig_q <= '0;
        end
    end

    // Software clearing active on any active channel, whether or not it owns the bus
    always_comb begin
        abort = '0;
        if (apb_wr && paddr == `DA_OFF_CTRL) begin
            abort = act_q & ~pwdata[`DA_F_ACT+:`DA_NCH];
        end
    end

    // Per-channel trigger slots
    genvar g;
    generate
        for (g = 0; g < `DA_NCH; g++) begin : g_ch
            dmaarb_latency u_lat (
                .clk_sys    (clk_sys),
                .rst_sync_n (rst_sync_n),
                .trig       ((trig[g] || swtrig_q[g]) && act_q[g]),
                .hold_off   (hold_q[g]),
                .ack        (ack[g]),
                .clear      (!act_q[g] || cpu.stop),
                .pend       (pend[g]),
                .ready      (ready[g])
            );

            // Pointer and count; software write wins over update
            always_ff @(posedge clk_sys or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    ptr_q[g] <= `DA_PTR_RST;
                    cnt_q[g] <= `DA_CNT_RST;
                end else if (apb_wr && paddr ==
                             `DA_OFF_PTR0 + `DA_STRIDE * g) begin
                    ptr_q[g] <= pwdata[`DA_AW-1:0];
                end else if (apb_wr && paddr ==
                             `DA_OFF_CNT0 + `DA_STRIDE * g) begin
                    cnt_q[g] <= pwdata[`DA_CW-1:0];
                end else if (fin && cur_q == g) begin
                    ptr_q[g] <= ptr_q[g] + `DA_PTR_ONE;
                    cnt_q[g] <= cnt_q[g] - `DA_CNT_ONE;
                end
            end
        end
    endgenerate

    // Hold one cycle after a listed instruction ends
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            supp_q <= 1'b0;
        end else begin
            supp_q <= cpu.suppress;
        end
    end

    // Grant only from idle, so a new request waits for the bus
    assign cand  = ready & act_q & ~abort;
    assign grant = (state_q == DA_IDLE) && (cand != '0) && !cpu.stop &&
                   !supp_q && !cpu.suppress_busy &&
                   !cpu.flash_acc;
    assign ack   = grant ? pick_low(cand) : '0;
    assign fin   = (state_q == DA_XFER2) && !abort[cur_q] && !cpu.stop;

    always_comb begin
        done = '0;
        if (fin && cnt_q[cur_q] == `DA_CNT_ONE) begin
            done[cur_q] = 1'b1;
        end
    end

    // Two-clock bus transfer
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_q <= DA_IDLE;
            cur_q   <= '0;
        end else begin
            case (state_q)
                DA_IDLE: begin
                    if (grant) begin
                        state_q <= DA_XFER1;
                        cur_q   <= enc(ack);
                    end
                end
                DA_XFER1: begin
                    if (abort[cur_q] || cpu.stop) begin
                        state_q <= DA_IDLE;
                    end else begin
                        state_q <= DA_XFER2;
                    end
                end
                DA_XFER2: begin
                    state_q <= DA_IDLE;
                end
                default: begin
                    state_q <= DA_IDLE;
                end
            endcase
        end
    end

    // Bus outputs registered alongside the state
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            bus <= '0;
        end else if (grant) begin
            bus.req    <= 1'b1;
            bus.ch     <= enc(ack);
            bus.to_sfr <= dir_q[enc(ack)];
            bus.addr   <= ptr_q[enc(ack)];
            // Bad pointer: write dropped or read undefined
            bus.drop   <= addr_bad(ptr_q[enc(ack)]);
        end else if ((state_q == DA_XFER1 && (abort[cur_q] || cpu.stop)) ||
                     state_q == DA_XFER2) begin
            bus.req  <= 1'b0;
            bus.drop <= 1'b0;
        end
    end

    // Interrupts wait while a transfer is ready or running
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cpu_irq_allow <= 1'b1;
        end else begin
            cpu_irq_allow <= !grant && (state_q == DA_IDLE) &&
                             !((cand != '0) && cpu.irq_req &&
                               !cpu.stop);
        end
    end

    // Flash access right after a transfer stalls three clocks
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            after_xfer_q <= 1'b0;
            wait_cnt_q   <= '0;
            cpu_wait     <= 1'b0;
        end else begin
            after_xfer_q <= fin || (after_xfer_q && !cpu.flash_acc &&
                                    state_q != DA_IDLE);
            if (after_xfer_q && cpu.flash_acc && wait_cnt_q == '0) begin
                wait_cnt_q <= `DA_FLASH_WAIT;
                cpu_wait   <= 1'b1;
            end else if (wait_cnt_q != '0) begin
                wait_cnt_q <= wait_cnt_q - 2'h1;
                cpu_wait   <= (wait_cnt_q != 2'h1);
            end else begin
                cpu_wait   <= 1'b0;
            end
        end
    end

    // Done status: set wins over write-one-to-clear
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            istat_q <= '0;
            imask_q <= '0;
            irq     <= 1'b0;
        end else begin
            if (apb_wr && paddr == `DA_OFF_ISTAT) begin
                istat_q <= (istat_q & ~pwdata[`DA_NCH-1:0]) | done;
            end else begin
                istat_q <= istat_q | done;
            end
            if (apb_wr && paddr == `DA_OFF_IMASK) begin
                imask_q <= pwdata[`DA_NCH-1:0];
            end
            irq <= ((istat_q | done) & imask_q) != '0;
        end
    end

endmodule : dmaarb_top

// ==== pkg/dmaarb_defs.svh ====
/*
 * Constants of the DMA channel arbiter: register offsets, field
 * positions, reset values and timing counts.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef DMAARB_DEFS_SVH
`define DMAARB_DEFS_SVH

`define DA_NCH           4
`define DA_CHW           2
`define DA_AW            16
`define DA_CW            10
`define DA_PAW           8

`define DA_OFF_PTR0      8'h00
`define DA_OFF_CNT0      8'h10
`define DA_OFF_CTRL      8'h20
`define DA_OFF_ISTAT     8'h24
`define DA_OFF_IMASK     8'h28
`define DA_OFF_STATUS    8'h2C
`define DA_OFF_TRIG      8'h30
`define DA_STRIDE        8'h04
`define DA_PTR_LAST      8'h0C
`define DA_CNT_LAST      8'h1C

`define DA_F_EN          0
`define DA_F_ACT         4
`define DA_F_HOLD        8
`define DA_F_DIR         12
`define DA_F_PEND        0
`define DA_F_BUSY        4
`define DA_F_CUR         5
`define DA_F_BAD         7

`define DA_PTR_RST       16'h0000
`define DA_CNT_RST       10'h000
`define DA_CNT_ONE       10'h001
`define DA_PTR_ONE       16'h0001
`define DA_GPR_LO        16'hFEE0
`define DA_GPR_HI        16'hFEFF
`define DA_RAM_LO        16'hF800
`define DA_RAM_HI        16'hFFFF

`define DA_LAT_MIN_CLK   3
`define DA_LAT_MAX_CLK   10
`define DA_AGE_W         4
`define DA_AGE_READY     4'h2
`define DA_AGE_MAX       4'hF
`define DA_HOLD_DLY      2
`define DA_FLASH_WAIT    2'h3
`define DA_ZERO32        32'h0000_0000

`endif

// ==== pkg/dmaarb_pkg.sv ====
/*
 * Types of the DMA channel arbiter.
 * Assumes the constants header is on the include path.
 */
`include "dmaarb_defs.svh"

package dmaarb_pkg;

    typedef struct packed {
        logic irq_req;
        logic suppress;
        logic suppress_busy;
        logic flash_acc;
        logic halt;
        logic stop;
    } dmaarb_cpu_t;

    typedef struct packed {
        logic                  req;
        logic                  to_sfr;
        logic [`DA_CHW-1:0]    ch;
        logic [`DA_AW-1:0]     addr;
        logic                  drop;
    } dmaarb_bus_t;

    typedef enum logic [1:0] {
        DA_IDLE,
        DA_XFER1,
        DA_XFER2
    } dmaarb_state_t;

endpackage : dmaarb_pkg

// ==== tb/dma_channel_arbiter_timing_tb.sv ====
/* Self-checking bench of the DMA channel arbiter.
   Assumes the package, the partner model and the checker are compiled. */
`timescale 1ns/1ps
`include "dmaarb_defs.svh"

module dma_channel_arbiter_timing_tb;
    import dmaarb_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, er, cpu_irq_allow, cpu_wait, irq;
    logic [3:0] fire = 4'h0, trig;
    logic sup_go = 1'b0, irq_in = 1'b0, flash_in = 1'b0;
    logic halt_in = 1'b0, stop_in = 1'b0;
    dmaarb_cpu_t cpu;
    dmaarb_bus_t bus;
    int bad_count = 0;
    int checks_done = 0;

    always #10 clk_sys = ~clk_sys;

    dmaarb_top u_dmaarb_top (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig(trig),
        .cpu(cpu), .bus(bus), .cpu_irq_allow(cpu_irq_allow),
        .cpu_wait(cpu_wait), .irq(irq));
    dmaarb_cpu_model u_dmaarb_cpu_model (.clk_sys(clk_sys), .rst_n(rst_n),
        .fire(fire), .sup_go(sup_go), .irq_in(irq_in), .flash_in(flash_in),
        .halt_in(halt_in), .stop_in(stop_in), .trig(trig), .cpu(cpu));

    task automatic fail(input string m);
        bad_count++;
        $display("wrong value at %0t: %s", $time, m);
    endtask : fail

    task automatic chk(input logic [31:0] got, exp, input string m);
        checks_done++;
        if (got !== exp) fail(m);
    endtask : chk

    // Holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task automatic setup(input int ch, input logic [15:0] p,
                         input logic [9:0] c);
        apb(1'b1, 8'(`DA_OFF_PTR0 + `DA_STRIDE * ch), {16'h0, p});
        apb(1'b1, 8'(`DA_OFF_CNT0 + `DA_STRIDE * ch), {22'h0, c});
    endtask : setup

    task automatic kick(input logic [3:0] m);
        fire <= m;
        @(posedge clk_sys);
        fire <= 4'h0;
    endtask : kick

    task automatic wait_req(output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (bus.req !== 1'b1 && n < 40);
    endtask : wait_req

    task automatic count(input bit w, input int cyc, output int n);
        n = 0;
        repeat (cyc) begin
            @(posedge clk_sys);
            if ((w ? cpu_wait : bus.req) === 1'b1) n++;
        end
    endtask : count

    task automatic t_regs;
        apb(1'b0, `DA_OFF_PTR0, '0);
        chk(rd, 0, "pointer after reset");
        apb(1'b0, `DA_OFF_STATUS, '0);
        chk(rd, 32'h80, "pending after reset");
        apb(1'b0, 8'h3C, '0);
        chk({31'h0, er}, 32'h1, "unmapped address");
    endtask : t_regs

    task automatic t_single;
        int n;
        setup(0, 16'hFEDF, 10'h2);
        apb(1'b1, `DA_OFF_IMASK, 32'hF);
        apb(1'b1, `DA_OFF_CTRL, 32'h11);
        irq_in <= 1'b1;
        kick(4'h1);
        wait_req(n);
        chk(32'(n >= `DA_LAT_MIN_CLK && n <= `DA_LAT_MAX_CLK), 1, "latency");
        chk({bus.drop, bus.ch, bus.addr}, 19'hFEDF, "beat");
        chk(cpu_irq_allow, 0, "irq before transfer");
        @(posedge clk_sys);
        chk(bus.req, 1, "second clock");
        flash_in <= 1'b1;
        @(posedge clk_sys);
        chk(bus.req, 0, "bus released");
        flash_in <= 1'b0;
        irq_in <= 1'b0;
        count(1'b1, 5, n);
        chk(n, 3, "flash wait");
        apb(1'b0, `DA_OFF_PTR0, '0);
        chk(rd, 32'hFEE0, "pointer step");
        apb(1'b0, `DA_OFF_CNT0, '0);
        chk(rd, 32'h1, "count step");
        repeat (8) @(posedge clk_sys);
        kick(4'h1);
        wait_req(n);
        chk({bus.drop, bus.addr}, {1'b1, 16'hFEE0}, "register area");
        repeat (6) @(posedge clk_sys);
        apb(1'b0, `DA_OFF_CTRL, '0);
        chk(rd, 32'h1, "active flag");
        apb(1'b0, `DA_OFF_ISTAT, '0);
        chk(rd, 32'h1, "done status");
        chk(irq, 1, "done interrupt");
        apb(1'b1, `DA_OFF_ISTAT, 32'h1);
        apb(1'b0, `DA_OFF_ISTAT, '0);
        chk({rd[31:1], irq}, 0, "status clear");
    endtask : t_single

    task automatic t_prio;
        int n;
        for (int i = 0; i < 4; i++)
            setup(i, 16'(16'hF800 + 'h100 * i), 10'h4);
        apb(1'b1, `DA_OFF_CTRL, 32'hA0FF);
        kick(4'hF);
        for (int i = 0; i < 4; i++) begin
            wait_req(n);
            chk({bus.to_sfr, bus.ch}, i + 4 * (i % 2), "grant order");
            @(posedge clk_sys);
        end
        apb(1'b1, `DA_OFF_CTRL, '0);
    endtask : t_prio

    task automatic t_hold;
        int n;
        setup(1, 16'hF900, 10'h4);
        apb(1'b1, `DA_OFF_CTRL, 32'h222);
        repeat (2) @(posedge clk_sys);
        kick(4'h2);
        repeat (12) @(posedge clk_sys);
        kick(4'h2);
        count(1'b0, 20, n);
        chk(n, 0, "held transfer");
        apb(1'b1, `DA_OFF_CTRL, 32'h22);
        count(1'b0, 30, n);
        chk(n, 2, "one after release");
    endtask : t_hold

    task automatic t_abort;
        int n;
        setup(2, 16'hFA00, 10'h3);
        apb(1'b1, `DA_OFF_CTRL, 32'h44);
        kick(4'h4);
        repeat (2) @(posedge clk_sys);
        apb(1'b1, `DA_OFF_CTRL, 32'h4);
        kick(4'h4);
        count(1'b0, 20, n);
        chk(n, 0, "aborted idle");
        apb(1'b0, 8'(`DA_OFF_PTR0 + 8'h8), '0);
        chk(rd, 32'hFA00, "pointer kept");
        apb(1'b0, 8'(`DA_OFF_CNT0 + 8'h8), '0);
        chk(rd, 32'h3, "count kept");
        apb(1'b0, `DA_OFF_ISTAT, '0);
        chk(rd, 0, "no done on abort");
    endtask : t_abort

    task automatic t_sleep;
        int n;
        setup(3, 16'hFB00, 10'h8);
        apb(1'b1, `DA_OFF_CTRL, 32'h88);
        stop_in <= 1'b1;
        kick(4'h8);
        count(1'b0, 20, n);
        chk(n, 0, "deep sleep");
        stop_in <= 1'b0;
        halt_in <= 1'b1;
        apb(1'b1, `DA_OFF_TRIG, 32'h8);
        wait_req(n);
        chk(32'(n <= `DA_LAT_MAX_CLK), 1, "light sleep");
        halt_in <= 1'b0;
        repeat (12) @(posedge clk_sys);
        sup_go <= 1'b1;
        kick(4'h8);
        sup_go <= 1'b0;
        wait_req(n);
        chk(32'(n > 3 && n <= `DA_LAT_MAX_CLK + 3), 1, "suppressed");
    endtask : t_sleep

    task automatic finish_test;
        if (bad_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_regs();
        t_single();
        t_prio();
        t_hold();
        t_abort();
        t_sleep();
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        fail("timeout");
        finish_test();
    end
endmodule : dma_channel_arbiter_timing_tb

bind dmaarb_top dmaarb_monitor u_dmaarb_monitor (.clk_sys(clk_sys),
    .rst_n(rst_n), .trig(trig), .cpu(cpu), .bus(bus),
    .cpu_irq_allow(cpu_irq_allow), .cpu_wait(cpu_wait), .irq(irq));

// ==== tb/dmaarb_cpu_model.sv ====
/* CPU core and trigger sources facing the arbiter.
   Assumes commands from the bench change right after clock edges. */
`timescale 1ns/1ps
`include "dmaarb_defs.svh"

module dmaarb_cpu_model (
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    input  wire logic [`DA_NCH-1:0]   fire,
    input  wire logic                 sup_go,
    input  wire logic                 irq_in,
    input  wire logic                 flash_in,
    input  wire logic                 halt_in,
    input  wire logic                 stop_in,
    output logic      [`DA_NCH-1:0]   trig,
    output dmaarb_pkg::dmaarb_cpu_t   cpu
);
    import dmaarb_pkg::*;
    logic [3:0] gap_q [`DA_NCH];
    logic [1:0] sup_q;

    // Retriggers within the slowest answer plus one clock are dropped
    always_comb begin
        for (int i = 0; i < `DA_NCH; i++) begin
            trig[i] = fire[i] && (gap_q[i] > `DA_LAT_MAX_CLK);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        for (int i = 0; i < `DA_NCH; i++) begin
            if (!rst_n) begin
                gap_q[i] <= 4'hF;
            end else if (trig[i]) begin
                gap_q[i] <= 4'h0;
            end else if (gap_q[i] != 4'hF) begin
                gap_q[i] <= gap_q[i] + 4'h1;
            end
        end
    end

    // A suppressing instruction runs three clocks, its end pulse last
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sup_q <= 2'h0;
        end else if (sup_go) begin
            sup_q <= 2'h3;
        end else if (sup_q != 2'h0) begin
            sup_q <= sup_q - 2'h1;
        end
    end

    // Flash access counts as a suppressing instruction itself
    assign cpu = '{irq_req: irq_in, suppress: sup_q == 2'h1,
                   suppress_busy: (sup_q != 2'h0) || flash_in,
                   flash_acc: flash_in, halt: halt_in, stop: stop_in};
endmodule : dmaarb_cpu_model

// ==== tb/dmaarb_monitor.sv ====
/* Port checker for the DMA channel arbiter.
   Assumes it is bound to dmaarb_top and sees only its ports. */
`timescale 1ns/1ps
`include "dmaarb_defs.svh"

module dmaarb_monitor (
    input wire logic                    clk_sys,
    input wire logic                    rst_n,
    input wire logic [`DA_NCH-1:0]      trig,
    input wire dmaarb_pkg::dmaarb_cpu_t cpu,
    input wire dmaarb_pkg::dmaarb_bus_t bus,
    input wire logic                    cpu_irq_allow,
    input wire logic                    cpu_wait,
    input wire logic                    irq
);
    import dmaarb_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // A back-to-back grant would keep req high into a third clock
    a_xfer_two_clk:
    assert property ($rose(bus.req) |=> bus.req ##1 !bus.req)
        else $error("transfer length wrong");
    a_min_latency:
    assert property ($rose(bus.req) |->
        !(($past(trig, 1) | $past(trig, 2)) & (4'h1 << bus.ch)))
        else $error("transfer started too soon");
    a_stop_quiet:
    assert property (cpu.stop [*3] |-> !bus.req)
        else $error("transfer in deep sleep");
    a_busy_defer:
    assert property (cpu.suppress_busy |=> !$rose(bus.req))
        else $error("transfer while suppressed");
    a_after_sup:
    assert property (cpu.suppress |=> ##1 !$rose(bus.req))
        else $error("transfer just after suppress");
    a_irq_defer:
    assert property (bus.req && cpu.irq_req |-> !cpu_irq_allow)
        else $error("interrupt allowed during transfer");
    a_flash_wait:
    assert property ($fell(bus.req) && cpu.flash_acc |=> cpu_wait [*3])
        else $error("flash wait missing");
    a_bad_addr:
    assert property (bus.req |-> bus.drop == (bus.addr < `DA_RAM_LO ||
        (bus.addr >= `DA_GPR_LO && bus.addr <= `DA_GPR_HI)))
        else $error("drop flag wrong");
    a_reset_idle:
    assert property (disable iff (1'b0)
        $rose(rst_n) |-> !bus.req && !cpu_wait && !irq)
        else $error("not idle after reset");
endmodule : dmaarb_monitor
